// [ctc_pkg.sv]
// Package: shared constants and types for command/address termination
package ctc_pkg;
	// ********************************************
	// Mode register addresses and fields
	// ********************************************
	localparam logic [5:0] CTC_ADDR_CONFIG   = 6'h0b;
	localparam logic [5:0] CTC_ADDR_OVERRIDE = 6'h16;
	localparam int         CTC_VAL_LSB       = 4;
	localparam int         CTC_VAL_MSB       = 6;
	localparam int         CTC_PU_BIT        = 0;
	localparam int         CTC_CK_FORCE_BIT  = 3;
	localparam int         CTC_CS_FORCE_BIT  = 4;
	localparam int         CTC_CA_DIS_BIT    = 5;
	localparam logic [7:0] CTC_CONFIG_RESET  = 8'h00;
	localparam logic [7:0] CTC_OVERRIDE_RESET = 8'h00;

	// ********************************************
	// Termination value codes
	// ********************************************
	typedef enum logic [2:0]
	{
		CTC_RTT_OFF = 3'h0,
		CTC_RTT_240 = 3'h1,
		CTC_RTT_120 = 3'h2,
		CTC_RTT_80  = 3'h3,
		CTC_RTT_60  = 3'h4,
		CTC_RTT_48  = 3'h5,
		CTC_RTT_40  = 3'h6,
		CTC_RTT_RSV = 3'h7
	} ctc_rtt_type;

	// ********************************************
	// Timing
	// ********************************************
	localparam int CTC_CLK_PERIOD_PS  = 10000;
	localparam int CTC_UPDATE_TIME_NS = 20;
	localparam int CTC_UPDATE_CYCLES  =
		(CTC_UPDATE_TIME_NS * 1000 + CTC_CLK_PERIOD_PS - 1)
		/ CTC_CLK_PERIOD_PS;
	localparam logic [3:0] CTC_UPDATE_CNT =
		4'(CTC_UPDATE_CYCLES < 1 ? 1 : CTC_UPDATE_CYCLES);

	// ********************************************
	// Controller register map (AHB-Lite)
	// ********************************************
	localparam logic [7:0] CTC_REG_CMD    = 8'h00;
	localparam logic [7:0] CTC_REG_STATUS = 8'h04;
	localparam int CTC_CMD_DATA_LSB = 0;
	localparam int CTC_CMD_ADDR_LSB = 8;
	localparam int CTC_CMD_GO_BIT   = 31;
	localparam int CTC_ST_BUSY_BIT  = 0;
	localparam int CTC_ST_ERR_BIT   = 1;
	localparam int CTC_ST_PU_BIT    = 2;
	localparam int CTC_ST_CAL_BIT   = 3;
	localparam logic [1:0] CTC_HTRANS_NONSEQ = 2'h2;
endpackage

// [ctc_if.sv]
// Interface: mode register write link between controller and device
interface ctc_if;
	logic       mrw_valid;
	logic [5:0] mrw_addr;
	logic [7:0] mrw_data;

	modport ctrl
	(
		output mrw_valid,
		output mrw_addr,
		output mrw_data
	);
	modport dev
	(
		input mrw_valid,
		input mrw_addr,
		input mrw_data
	);
endinterface

// [ctc_device.sv]
// Module: device-side command/address termination decode
//
// Functional notes
// RULE1: CA termination value from config bits 6:4
// RULE2: Termination value field resets to disabled
// RULE3: Termination persists through power-down states
// RULE4: Strap low never terminates CA lines
// RULE5: Strap high, field enabled: CA terminated (code: only while override bit 5, the CA disable bit, is clear)
// RULE6: Resolve CA, clock, select from table
// RULE7: Strap sample unchanged on power-down entry
// RULE8: Controller may change value without recalibration
// RULE9: Pull-up point change needs recalibration
// RULE10: Higher pull-up point forbids 60/48/40
// RULE11: Train terminating rank before others
// RULE12: New setting applied after 20 ns
// RULE13: Codes 1..6 map 240..40 ohm
module ctc_device
	import ctc_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	ctc_if.dev               link,
	input  wire logic        ca_term_strap_pad,
	input  wire logic        power_down,
	output ctc_pkg::ctc_rtt_type ca_rtt,
	output logic             ca_term_on,
	output logic             clock_term_on,
	output logic             chip_select_term_on,
	output logic             pending
);
	import ctc_pkg::*;

	// ********************************************
	// Mode registers
	// ********************************************
	logic [7:0]  termination_config_reg_q;
	logic [7:0]  termination_override_reg_q;
	logic        strap_q;
	logic        strap_taken_q;
	logic [3:0]  upd_cnt_q;
	logic [2:0]  ca_term_value_field;
	logic        ca_term_disable_bit;
	logic        clock_term_force_bit;
	logic        chip_select_term_force_bit;
	ctc_rtt_type rtt_d;
	logic        ca_d;
	logic        ck_d;
	logic        cs_d;
	logic        upd_hit;
	logic        apply_now;

	// Power-down does not reset these; only hresetn does
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			termination_config_reg_q <= CTC_CONFIG_RESET; // RULE2
		else if (link.mrw_valid && link.mrw_addr == CTC_ADDR_CONFIG)
			termination_config_reg_q <= link.mrw_data;
	end

	// Force and disable bits wait for the same update timer as the value
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			termination_override_reg_q <= CTC_OVERRIDE_RESET;
		else if (link.mrw_valid && link.mrw_addr == CTC_ADDR_OVERRIDE)
			termination_override_reg_q <= link.mrw_data;
	end

	// ********************************************
	// Strap capture
	// ********************************************
	// Bond pad is static; caught once after reset release and never
	// resampled, so power-down entry cannot disturb it
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			strap_q <= 1'b0;
		else if (!strap_taken_q && !power_down) // RULE7
			strap_q <= ca_term_strap_pad;
	end

	// Taken flag only ever rises; only a fresh reset resamples the pad
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			strap_taken_q <= 1'b0;
		else if (!power_down)
			strap_taken_q <= 1'b1;
	end

	// ********************************************
	// Update timer
	// ********************************************
	// Writes to other mode registers must not restart the wait
	assign upd_hit = link.mrw_valid &&
		(link.mrw_addr == CTC_ADDR_CONFIG ||
		link.mrw_addr == CTC_ADDR_OVERRIDE);

	// A new write restarts the wait rather than queueing behind it
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			upd_cnt_q <= 4'h0;
		else if (upd_hit)
			upd_cnt_q <= CTC_UPDATE_CNT; // RULE12
		else if (upd_cnt_q != 4'h0)
			upd_cnt_q <= upd_cnt_q - 4'h1;
	end

	// ********************************************
	// Termination resolve
	// ********************************************
	assign ca_term_value_field =
		termination_config_reg_q[CTC_VAL_MSB:CTC_VAL_LSB]; // RULE1
	assign ca_term_disable_bit = termination_override_reg_q[CTC_CA_DIS_BIT];
	assign clock_term_force_bit =
		termination_override_reg_q[CTC_CK_FORCE_BIT];
	assign chip_select_term_force_bit =
		termination_override_reg_q[CTC_CS_FORCE_BIT];

	always_comb
	begin
		rtt_d = CTC_RTT_OFF;
		ca_d  = 1'b0;
		ck_d  = 1'b0;
		cs_d  = 1'b0;
		case (ca_term_value_field) // RULE13
			3'h1: rtt_d = CTC_RTT_240;
			3'h2: rtt_d = CTC_RTT_120;
			3'h3: rtt_d = CTC_RTT_80;
			3'h4: rtt_d = CTC_RTT_60;
			3'h5: rtt_d = CTC_RTT_48;
			3'h6: rtt_d = CTC_RTT_40;
			// Reserved code is treated as disabled
			default: rtt_d = CTC_RTT_OFF;
		endcase
		// Disabled value field switches every termination off
		if (rtt_d != CTC_RTT_OFF) // RULE6
		begin
			if (!strap_q)
			begin
				ca_d = 1'b0; // RULE4
				ck_d = clock_term_force_bit;
				cs_d = chip_select_term_force_bit;
			end
			else
			begin
				ca_d = !ca_term_disable_bit; // RULE5
				ck_d = 1'b1;
				cs_d = 1'b1;
			end
		end
		// No resistance is reported while the CA lines stay open
		if (!ca_d)
			rtt_d = CTC_RTT_OFF;
	end

	// ********************************************
	// Output registers
	// ********************************************
	// Outputs hold through power-down; power_down is not a term here.
	// Idle outputs follow the resolve only once the strap is caught.
	assign apply_now = upd_cnt_q == 4'h1 ||
		(upd_cnt_q == 4'h0 && strap_taken_q);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			ca_rtt <= CTC_RTT_OFF;
		else if (apply_now)
			ca_rtt <= rtt_d; // RULE3
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			ca_term_on <= 1'b0;
		else if (apply_now)
			ca_term_on <= ca_d; // RULE3
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			clock_term_on <= 1'b0;
		else if (apply_now)
			clock_term_on <= ck_d;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			chip_select_term_on <= 1'b0;
		else if (apply_now)
			chip_select_term_on <= cs_d;
	end

	// ********************************************
	// Update status
	// ********************************************
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			pending <= 1'b0;
		else
			pending <= (upd_cnt_q > 4'h1) || upd_hit;
	end
endmodule

// [ctc_ctrl.sv]
// Module: controller end issuing mode register writes from AHB-Lite
module ctc_ctrl
	import ctc_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        cal_done,
	ctc_if.ctrl              link
);
	import ctc_pkg::*;

	// ********************************************
	// Bus slave
	// ********************************************
	logic       wr_pend_q;
	logic [7:0] addr_q;
	logic       pullup_high_level_point_q;
	logic       cal_needed_q;
	logic       err_q;
	logic       go;
	logic [5:0] w_addr;
	logic [7:0] w_data;
	logic       bad;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_q <= 1'b0;
			addr_q    <= 8'h00;
		end
		else if (hready)
		begin
			wr_pend_q <= hsel && hwrite && htrans == CTC_HTRANS_NONSEQ;
			addr_q    <= haddr[7:0];
		end
	end

	assign go = wr_pend_q && addr_q == CTC_REG_CMD &&
		hwdata[CTC_CMD_GO_BIT];
	assign w_addr = hwdata[CTC_CMD_ADDR_LSB +: 6];
	assign w_data = hwdata[CTC_CMD_DATA_LSB +: 8];
	// Forbidden combination: high pull-up point with 60/48/40 ohm
	assign bad = w_addr == CTC_ADDR_CONFIG && w_data[CTC_PU_BIT] &&
		w_data[CTC_VAL_MSB:CTC_VAL_LSB] >= CTC_RTT_60 &&
		w_data[CTC_VAL_MSB:CTC_VAL_LSB] <= CTC_RTT_40; // RULE10

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			link.mrw_valid <= 1'b0;
			link.mrw_addr  <= 6'h00;
			link.mrw_data  <= 8'h00;
		end
		else
		begin
			link.mrw_valid <= go && !bad;
			if (go && !bad)
			begin
				link.mrw_addr <= w_addr;
				link.mrw_data <= w_data;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pullup_high_level_point_q <= 1'b0;
			cal_needed_q              <= 1'b0;
		end
		else if (go && !bad && w_addr == CTC_ADDR_CONFIG &&
			w_data[CTC_PU_BIT] != pullup_high_level_point_q)
		begin
			pullup_high_level_point_q <= w_data[CTC_PU_BIT];
			cal_needed_q              <= 1'b1; // RULE9
		end
		else if (cal_done)
			cal_needed_q <= 1'b0; // RULE8
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			err_q <= 1'b0;
		else if (go && bad)
			err_q <= 1'b1;
		else if (wr_pend_q && addr_q == CTC_REG_STATUS &&
			hwdata[CTC_ST_ERR_BIT])
			err_q <= 1'b0;
	end

	// Read data registered from the address phase: zero wait states
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= 32'h0000_0000;
		else if (hready && hsel && !hwrite && htrans == CTC_HTRANS_NONSEQ)
		begin
			hrdata <= 32'h0000_0000;
			if (haddr[7:0] == CTC_REG_STATUS)
			begin
				hrdata[CTC_ST_BUSY_BIT] <= link.mrw_valid;
				hrdata[CTC_ST_ERR_BIT]  <= err_q;
				hrdata[CTC_ST_PU_BIT]   <= pullup_high_level_point_q;
				hrdata[CTC_ST_CAL_BIT]  <= cal_needed_q;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end
endmodule

// [ctc_props.sv]
// Checker: link and termination output assertions
module ctc_props
	import ctc_pkg::*;
(
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        mrw_valid,
	input wire logic [5:0]  mrw_addr,
	input wire logic [7:0]  mrw_data,
	input wire logic        ca_term_strap_pad,
	input ctc_rtt_type      ca_rtt,
	input wire logic        ca_term_on,
	input wire logic        clock_term_on,
	input wire logic        chip_select_term_on,
	input wire logic        pending
);
	wire logic [5:0] st = {ca_rtt, ca_term_on, clock_term_on,
		chip_select_term_on};
	logic      [2:0] cfg_q;
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// Last value field seen on the link
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			cfg_q <= 3'h0;
		else if (mrw_valid && mrw_addr == CTC_ADDR_CONFIG)
			cfg_q <= mrw_data[CTC_VAL_MSB:CTC_VAL_LSB];

	strap_low_a: assert property (
		!ca_term_strap_pad |-> !ca_term_on) else $error("CA on, strap low");
	all_off_a: assert property (
		!pending && cfg_q inside {CTC_RTT_OFF, CTC_RTT_RSV} |-> st == 6'h00)
		else $error("term on, value disabled");
	ca_code_a: assert property (
		ca_term_on |-> ca_rtt inside {[CTC_RTT_240:CTC_RTT_40]})
		else $error("bad CA code");
	strap_high_a: assert property (
		ca_term_strap_pad && ca_rtt != CTC_RTT_OFF |->
		clock_term_on && chip_select_term_on) else $error("ck/cs off");
	update_wait_a: assert property (
		mrw_valid |=> pending [*2]) else $error("pending short");
	early_hold_a: assert property (
		mrw_valid |=> $stable(st) [*2]) else $error("early update");
	quiet_hold_a: assert property (
		!$past(pending) |-> $stable(st)) else $error("state drifted");
	cfg_value_a: assert property (
		mrw_valid && mrw_addr == CTC_ADDR_CONFIG &&
		mrw_data[CTC_VAL_MSB:CTC_VAL_LSB] != CTC_RTT_RSV
		##1 !mrw_valid [*2] |=> (ca_term_on ? ca_rtt == cfg_q :
		ca_rtt == CTC_RTT_OFF)) else $error("bad value");
endmodule

// [ca_termination_control_tb_top.sv]
// Testbench: AHB-driven controller and device end
module ca_termination_control_tb_top import ctc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
	logic        ca_term_strap_pad = 1, power_down = 0, cal_done = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
	logic [1:0]  htrans = 0;
	logic [2:0]  hsize = 0;
	logic        hreadyout, hresp, ca_term_on, clock_term_on;
	logic        chip_select_term_on, pending;
	ctc_rtt_type ca_rtt;
	int          num_errors = 0, total_checks = 0;
	wire  [5:0]  st = {ca_rtt, ca_term_on, clock_term_on,
		chip_select_term_on};
	ctc_if       lnk ();

	ctc_ctrl i_ctc_ctrl (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
		.cal_done, .link(lnk));
	ctc_device i_ctc_device (.hclk, .hresetn, .link(lnk), .ca_term_strap_pad,
		.power_down, .ca_rtt, .ca_term_on, .clock_term_on,
		.chip_select_term_on, .pending);
	ctc_props i_ctc_props (.hclk, .hresetn, .mrw_valid(lnk.mrw_valid),
		.mrw_addr(lnk.mrw_addr), .mrw_data(lnk.mrw_data), .ca_term_strap_pad,
		.ca_rtt, .ca_term_on, .clock_term_on, .chip_select_term_on, .pending);

	initial forever #5 hclk = ~hclk;

	task finish_test;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e)
		begin
			num_errors++;
			$display("unexpected at %0t: %h not %h", $time, s, e);
		end
	endtask

	// Bounded wait for the slave's ready at a rising edge
	task rdy;
		int n;
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
		end
		while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1)
		begin
			num_errors++;
			finish_test;
		end
	endtask

	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= 32'(a);
		htrans <= CTC_HTRANS_NONSEQ;
		hwrite <= w;
		hsize <= 3'h2;
		rdy;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rdy;
		r = hrdata;
	endtask

	// Wait out link delivery plus the update time
	task mr(input logic [5:0] a, input logic [7:0] d);
		bus(1'b1, CTC_REG_CMD, {1'b1, 17'h0_0000, a, d});
		repeat (8) @(posedge hclk);
	endtask

	// Expected {resistance, CA, clock, select}; open CA lines show no value
	function logic [5:0] ex(input logic s, input logic [2:0] c,
		input logic [7:0] o);
		if (c == 3'h0 || c == 3'h7)
			return 6'h00;
		if (!s)
			return {3'h0, 1'b0, o[CTC_CK_FORCE_BIT], o[CTC_CS_FORCE_BIT]};
		if (o[CTC_CA_DIS_BIT])
			return {3'h0, 3'b011};
		return {c, 3'b111};
	endfunction

	task rst(input logic s);
		hresetn <= 1'b0;
		ca_term_strap_pad <= s;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
	endtask

	initial
	begin
		rst(1'b1);
		chk(st, 6'h00);
		bus(1'b0, CTC_REG_STATUS, 32'h0);
		chk(r, 32'h0);
		for (int c = 1; c < 7; c++)
		begin
			mr(CTC_ADDR_CONFIG, 8'(c << 4));
			chk(st, ex(1'b1, 3'(c), 8'h00));
		end
		power_down <= 1'b1;
		repeat (20) @(posedge hclk);
		chk(st, ex(1'b1, 3'h6, 8'h00));
		power_down <= 1'b0;
		$display("value and hold tests done");
		mr(CTC_ADDR_CONFIG, 8'h41);
		chk(st, ex(1'b1, 3'h6, 8'h00));
		bus(1'b0, CTC_REG_STATUS, 32'h0);
		chk(r[3:0], 4'h2);
		bus(1'b1, CTC_REG_STATUS, 32'h0000_0002);
		mr(CTC_ADDR_CONFIG, 8'h21);
		bus(1'b0, CTC_REG_STATUS, 32'h0);
		chk(r[3:0], 4'hc);
		cal_done <= 1'b1;
		@(posedge hclk);
		cal_done <= 1'b0;
		mr(CTC_ADDR_CONFIG, 8'h31);
		chk(st, ex(1'b1, 3'h3, 8'h00));
		bus(1'b0, CTC_REG_STATUS, 32'h0);
		chk(r[3:0], 4'h4);
		bus(1'b0, 8'h08, 32'h0);
		chk(r, 32'h0);
		mr(CTC_ADDR_OVERRIDE, 8'h20);
		chk(st, ex(1'b1, 3'h3, 8'h20));
		mr(CTC_ADDR_CONFIG, 8'h00);
		chk(st, 6'h00);
		$display("calibration tests done");
		rst(1'b0);
		mr(CTC_ADDR_CONFIG, 8'h20);
		for (int o = 0; o < 4; o++)
		begin
			mr(CTC_ADDR_OVERRIDE, 8'(o << 3) | 8'h20);
			chk(st, ex(1'b0, 3'h2, 8'(o << 3)));
		end
		$display("strap low tests done");
		finish_test;
	end
endmodule
